//--- sasd_pkg.sv
// Package of field positions, codes and register map for the SIMD decoder.
package sasd_pkg;
	// ==========================================================
	// Instruction fields
	localparam int SLOT_W     = 41;
	localparam int MAJ_HI     = 40;
	localparam int MAJ_LO     = 37;
	localparam int SZ_HI_BIT  = 36;
	localparam int SZ_LO_BIT  = 33;
	localparam int RSV_BIT    = 32;
	localparam int A2_HI      = 35;
	localparam int A2_LO      = 34;
	localparam int B2_HI      = 29;
	localparam int B2_LO      = 28;
	localparam int C2_HI      = 31;
	localparam int C2_LO      = 30;
	localparam int X4_HI      = 32;
	localparam int X4_LO      = 29;
	localparam int B8_HI      = 28;
	localparam int B8_LO      = 27;
	localparam int SHR5_HI    = 18;
	localparam int SHR5_LO    = 14;
	localparam int SHL5_HI    = 24;
	localparam int SHL5_LO    = 20;
	localparam int P4_HI      = 23;
	localparam int P4_LO      = 20;
	localparam int P8_HI      = 27;
	localparam int P8_LO      = 20;
	localparam logic [3:0] MAJ_MM  = 4'h7;
	localparam logic [3:0] MAJ_ALU = 4'h8;
	// ==========================================================
	// Decoded result codes
	typedef enum logic [4:0] {
		OP_NONE, OP_ADD, OP_SUB, OP_AVG, OP_AVG_DIFF, OP_CMP, OP_SHL_ADD,
		OP_SHR_ADD, OP_MUL_SHR, OP_INTERLEAVE, OP_WIDEN_IL, OP_MIN, OP_MAX,
		OP_ABS_DIFF_SUM, OP_NARROW_SAT, OP_MUL_WIDEN, OP_BYTE_PERM,
		OP_HALF_PERM, OP_SHR, OP_SHL
	} sasd_op_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_FULL} sasd_size_t;
	typedef enum logic [2:0] {IMM_NONE, IMM_AMT2, IMM_AMT5, IMM_PERM4, IMM_PERM8} sasd_imm_t;
	// Variant codes: add/sub reuse the ext_b2 value directly.
	localparam logic [2:0] V_MOD      = 3'h0;
	localparam logic [2:0] V_SIGNED   = 3'h1;
	localparam logic [2:0] V_UNSIGNED = 3'h2;
	localparam logic [2:0] V_RIGHT    = 3'h4;
	localparam logic [2:0] V_LEFT     = 3'h5;
	localparam logic [2:0] V_HIGH     = 3'h6;
	localparam logic [2:0] V_LOW      = 3'h7;
	localparam logic [2:0] V_RAZ      = 3'h3;
	// ==========================================================
	// Register map
	localparam int AW = 4;
	localparam logic [AW-1:0] REG_CTRL  = 4'h0;
	localparam logic [AW-1:0] REG_DCNT  = 4'h4;
	localparam logic [AW-1:0] REG_ICNT  = 4'h8;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int CNT_W = 16;
endpackage

//--- sasd_if.sv
// Interfaces carrying slot fields and register-side signals between modules.
`timescale 1ns/10ps
interface sasd_fld_if;
	logic [3:0] major;
	logic [1:0] size_code;
	logic       rsv;
	logic [1:0] a2;
	logic [1:0] b2;
	logic [1:0] c2;
	logic [3:0] x4;
	logic [1:0] b8;
	logic [7:0] perm8;
	logic [4:0] shr5;
	logic [4:0] shl5;
	modport src (output major, size_code, rsv, a2, b2, c2, x4, b8, perm8, shr5, shl5);
	modport dst (input major, size_code, rsv, a2, b2, c2, x4, b8, perm8, shr5, shl5);
endinterface

interface sasd_reg_if;
	logic        dec_en;
	logic        cnt_clr;
	logic [15:0] dec_cnt;
	logic [15:0] ill_cnt;
	modport regs (output dec_en, cnt_clr, input dec_cnt, ill_cnt);
	modport core (input dec_en, cnt_clr, output dec_cnt, ill_cnt);
endinterface

//--- sasd_fields.sv
// Field extraction from one instruction slot.
`timescale 1ns/10ps
module sasd_fields (
	// Slot
	input wire logic [sasd_pkg::SLOT_W-1:0] slot,
	// Fields
	sasd_fld_if.src                         fld
);
	import sasd_pkg::*;

	// ==========================================================
	// Extraction
	assign fld.major     = slot[MAJ_HI:MAJ_LO];
	assign fld.size_code = {slot[SZ_HI_BIT], slot[SZ_LO_BIT]};
	assign fld.rsv       = slot[RSV_BIT];
	assign fld.a2        = slot[A2_HI:A2_LO];
	assign fld.b2        = slot[B2_HI:B2_LO];
	assign fld.c2        = slot[C2_HI:C2_LO];
	assign fld.x4        = slot[X4_HI:X4_LO];
	assign fld.b8        = slot[B8_HI:B8_LO];
	assign fld.perm8     = slot[P8_HI:P8_LO];
	assign fld.shr5      = slot[SHR5_HI:SHR5_LO];
	assign fld.shl5      = slot[SHL5_HI:SHL5_LO];
endmodule

//--- sasd_avmm.sv
// Avalon-MM register slave: control and counters.
`timescale 1ns/10ps
module sasd_avmm (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rstn,
	// Avalon-MM
	input  wire logic [sasd_pkg::AW-1:0]  address,
	input  wire logic                     read,
	input  wire logic                     write,
	input  wire logic [31:0]              writedata,
	input  wire logic [3:0]               byteenable,
	output logic      [31:0]              readdata,
	output logic                          waitrequest,
	// Core side
	sasd_reg_if.regs                      rg
);
	import sasd_pkg::*;

	logic en_reg;
	logic clr_reg;

	// ==========================================================
	// Handshake: one wait cycle, then the answer edge.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			case (address)
			REG_CTRL: readdata <= {31'h0000_0000, en_reg};
			REG_DCNT: readdata <= {16'h0000, rg.dec_cnt};
			REG_ICNT: readdata <= {16'h0000, rg.ill_cnt};
			default:  readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Writes land on the edge where waitrequest is seen low.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			en_reg  <= CTRL_EN_RST;
			clr_reg <= 1'b0;
		end else begin
			clr_reg <= 1'b0;
			if (write && !waitrequest && address == REG_CTRL && byteenable[0]) begin
				en_reg  <= writedata[CTRL_EN_BIT];
				clr_reg <= writedata[CTRL_CLR_BIT];
			end
		end
	end

	assign rg.dec_en  = en_reg;
	assign rg.cnt_clr = clr_reg;
endmodule

//--- sasd_top.sv
// SIMD ALU and shift instruction decoder with register slave.
// Behaviour
// - Opcode 7 size chosen by bits 36,33.
// - Opcode 7 needs reserved bit 32 zero.
// - Opcode 7 ext fields at 35:34,29:28,31:30.
// - Opcode 7 sizes: byte, half, word, full.
// - Opcode 8 ALU needs ext_a2 one; three sizes.
// - Opcode 8 reads ext_four 32:29, ext_b2 28:27.
// - ext_four 0 is add; word modulo only.
// - ext_four 1 is sub; word modulo only.
// - Average, rounding average, avg-diff: byte, half.
// - ext_four 9 compare: equal or signed greater.
// - Halfword shift-and-add at ext_four 4, 6.
// - Halfword multiply-shift, signed or unsigned.
// - Byte interleave, widen, min, max, abs-diff-sum.
// - Halfword narrow, min, max, widening multiply.
// - Word narrow signed, interleave and widen only.
// - Byte permute with four-bit pattern.
// - Halfword permute with eight-bit selector.
// - Variable right shifts, signed or unsigned.
// - Fixed right shifts on half and word.
// - Variable left shifts on half, word, full.
// - Fixed left shifts on half and word.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module sasd_top (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rstn,
	// Issue side
	input  wire logic                          slot_valid,
	input  wire logic [sasd_pkg::SLOT_W-1:0]   slot,
	// Execution side
	output logic                               dec_valid,
	output logic                               dec_illegal,
	output sasd_pkg::sasd_op_t                 dec_op,
	output sasd_pkg::sasd_size_t               dec_size,
	output logic [2:0]                         dec_variant,
	output sasd_pkg::sasd_imm_t                dec_imm_sel,
	output logic [7:0]                         dec_imm,
	// Avalon-MM
	input  wire logic [sasd_pkg::AW-1:0]       address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic      [31:0]                   readdata,
	output logic                               waitrequest
);
	import sasd_pkg::*;

	sasd_fld_if fld ();
	sasd_reg_if rg ();

	sasd_op_t    op_next;
	sasd_size_t  size_next;
	logic [2:0]  var_next;
	sasd_imm_t   imm_sel_next;
	logic [7:0]  imm_next;
	logic        hit;
	logic        take;
	logic [CNT_W-1:0] dcnt_reg;
	logic [CNT_W-1:0] icnt_reg;

	sasd_fields u_fields (
		.slot (slot),
		.fld  (fld)
	);

	sasd_avmm u_avmm (
		.clock       (clock),
		.rstn        (rstn),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.byteenable  (byteenable),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.rg          (rg)
	);

	// ==========================================================
	// Decode
	// Kept purely combinational so a new slot decodes in one cycle; the cost is a
	// wide mux feeding the output flops.
	always_comb begin
		op_next      = OP_NONE;
		size_next    = sasd_size_t'(fld.size_code);
		var_next     = V_MOD;
		imm_sel_next = IMM_NONE;
		imm_next     = 8'h00;
		hit          = 1'b0;
		if (fld.major == MAJ_ALU && fld.a2 == 2'h1 && fld.size_code != 2'h3) begin
			case (fld.x4)
			4'h0, 4'h1: begin
				if (size_next != SZ_WORD || fld.b8 == 2'h0) begin
					op_next  = (fld.x4 == 4'h0) ? OP_ADD : OP_SUB;
					var_next = {1'b0, fld.b8};
					hit      = 1'b1;
				end
			end
			4'h2: begin
				if (size_next != SZ_WORD && fld.b8[1]) begin
					op_next  = OP_AVG;
					var_next = fld.b8[0] ? V_RAZ : V_MOD;
					hit      = 1'b1;
				end
			end
			4'h3: begin
				if (size_next != SZ_WORD && fld.b8 == 2'h2) begin
					op_next = OP_AVG_DIFF;
					hit     = 1'b1;
				end
			end
			4'h4, 4'h6: begin
				if (size_next == SZ_HALF) begin
					op_next      = (fld.x4 == 4'h4) ? OP_SHL_ADD : OP_SHR_ADD;
					imm_sel_next = IMM_AMT2;
					imm_next     = {6'h00, fld.b8};
					hit          = 1'b1;
				end
			end
			4'h9: begin
				if (!fld.b8[1]) begin
					op_next  = OP_CMP;
					var_next = fld.b8[0] ? V_SIGNED : V_MOD;
					hit      = 1'b1;
				end
			end
			default: hit = 1'b0;
			endcase
		end else if (fld.major == MAJ_MM && !fld.rsv) begin
			case ({fld.a2, fld.b2, fld.c2})
			// Variable shifts on every size except byte.
			6'b00_00_00, 6'b00_10_00: begin
				if (size_next != SZ_BYTE) begin
					op_next  = OP_SHR;
					var_next = fld.b2[1] ? V_SIGNED : V_UNSIGNED;
					hit      = 1'b1;
				end
			end
			6'b00_00_01: begin
				if (size_next != SZ_BYTE) begin
					op_next = OP_SHL;
					hit     = 1'b1;
				end
			end
			6'b01_01_00, 6'b01_11_00: begin
				if (size_next == SZ_HALF || size_next == SZ_WORD) begin
					op_next      = OP_SHR;
					var_next     = fld.b2[1] ? V_SIGNED : V_UNSIGNED;
					imm_sel_next = IMM_AMT5;
					imm_next     = {3'h0, fld.shr5};
					hit          = 1'b1;
				end
			end
			6'b11_01_01: begin
				if (size_next == SZ_HALF || size_next == SZ_WORD) begin
					op_next      = OP_SHL;
					imm_sel_next = IMM_AMT5;
					imm_next     = {3'h0, fld.shl5};
					hit          = 1'b1;
				end
			end
			6'b10_00_10, 6'b10_10_10: begin
				if (size_next != SZ_FULL) begin
					op_next  = OP_INTERLEAVE;
					var_next = fld.b2[1] ? V_LEFT : V_RIGHT;
					hit      = 1'b1;
				end
			end
			6'b10_00_01, 6'b10_10_01: begin
				if (size_next != SZ_FULL) begin
					op_next  = OP_WIDEN_IL;
					var_next = fld.b2[1] ? V_LOW : V_HIGH;
					hit      = 1'b1;
				end
			end
			6'b10_01_00, 6'b10_01_01: begin
				if (size_next == SZ_BYTE) begin
					op_next  = fld.c2[0] ? OP_MAX : OP_MIN;
					var_next = V_UNSIGNED;
					hit      = 1'b1;
				end
			end
			6'b10_11_10: begin
				if (size_next == SZ_BYTE) begin
					op_next = OP_ABS_DIFF_SUM;
					hit     = 1'b1;
				end
			end
			6'b10_00_00: begin
				if (size_next == SZ_HALF) begin
					op_next  = OP_NARROW_SAT;
					var_next = V_UNSIGNED;
					hit      = 1'b1;
				end
			end
			6'b10_10_00: begin
				if (size_next == SZ_HALF || size_next == SZ_WORD) begin
					op_next  = OP_NARROW_SAT;
					var_next = V_SIGNED;
					hit      = 1'b1;
				end
			end
			6'b10_11_00, 6'b10_11_01: begin
				if (size_next == SZ_HALF) begin
					op_next  = fld.c2[0] ? OP_MAX : OP_MIN;
					var_next = V_SIGNED;
					hit      = 1'b1;
				end
			end
			6'b10_01_11, 6'b10_11_11: begin
				if (size_next == SZ_HALF) begin
					op_next  = OP_MUL_WIDEN;
					var_next = fld.b2[1] ? V_LEFT : V_RIGHT;
					hit      = 1'b1;
				end
			end
			6'b11_10_10: begin
				if (size_next == SZ_BYTE) begin
					op_next      = OP_BYTE_PERM;
					imm_sel_next = IMM_PERM4;
					imm_next     = {4'h0, fld.perm8[3:0]};
					hit          = 1'b1;
				end else if (size_next == SZ_HALF) begin
					op_next      = OP_HALF_PERM;
					imm_sel_next = IMM_PERM8;
					imm_next     = fld.perm8;
					hit          = 1'b1;
				end
			end
			default: hit = 1'b0;
			endcase
			// The multiply-shift count sits in the ext_c2 bits, so it matches any c2.
			if (!hit && fld.a2 == 2'h0 && fld.b2[0] && size_next == SZ_HALF) begin
				op_next      = OP_MUL_SHR;
				var_next     = fld.b2[1] ? V_SIGNED : V_UNSIGNED;
				imm_sel_next = IMM_AMT2;
				imm_next     = {6'h00, fld.c2};
				hit          = 1'b1;
			end
		end
	end

	// ==========================================================
	// Output stage
	// Illegal slots never present an operation, so a datapath that ignores the
	// flag still cannot execute them.
	assign take = slot_valid && rg.dec_en;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dec_valid   <= 1'b0;
			dec_illegal <= 1'b0;
		end else begin
			dec_valid   <= take && hit;
			dec_illegal <= take && !hit;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dec_op      <= OP_NONE;
			dec_size    <= SZ_BYTE;
			dec_variant <= V_MOD;
			dec_imm_sel <= IMM_NONE;
			dec_imm     <= 8'h00;
		end else if (take) begin
			dec_op      <= hit ? op_next : OP_NONE;
			dec_size    <= size_next;
			dec_variant <= var_next;
			dec_imm_sel <= imm_sel_next;
			dec_imm     <= imm_next;
		end
	end

	// ==========================================================
	// Counters; a count in the clearing cycle is kept.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dcnt_reg <= '0;
			icnt_reg <= '0;
		end else begin
			dcnt_reg <= (rg.cnt_clr ? '0 : dcnt_reg) + CNT_W'(dec_valid);
			icnt_reg <= (rg.cnt_clr ? '0 : icnt_reg) + CNT_W'(dec_illegal);
		end
	end

	assign rg.dec_cnt = dcnt_reg;
	assign rg.ill_cnt = icnt_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_take_mm;
		take && slot[MAJ_HI:MAJ_LO] == MAJ_MM;
	endsequence
	sequence s_take_rsv;
		s_take_mm and slot[RSV_BIT];
	endsequence

	AST_RSV_ILLEGAL: assert property (s_take_rsv |=> dec_illegal && dec_op == OP_NONE)
		else $error("reserved bit set but not flagged illegal");
	AST_ONE_OF: assert property (!(dec_valid && dec_illegal))
		else $error("valid and illegal together");
	AST_ILL_CAUSE: assert property (dec_illegal |-> $past(slot_valid) && $past(rg.dec_en)
		&& dec_op == OP_NONE && dec_imm_sel == IMM_NONE)
		else $error("illegal without cause");
	AST_MAJOR: assert property (take && slot[MAJ_HI:MAJ_LO] != MAJ_MM
		&& slot[MAJ_HI:MAJ_LO] != MAJ_ALU |=> dec_illegal)
		else $error("foreign opcode not flagged");
	AST_WORD_ADD: assert property (take && slot[MAJ_HI:MAJ_LO] == MAJ_ALU
		&& slot[SZ_HI_BIT] && !slot[SZ_LO_BIT] && slot[X4_HI:X4_LO] == 4'h0
		&& slot[B8_HI:B8_LO] != 2'h0 |=> dec_illegal)
		else $error("word saturating add accepted");
	AST_SIZE: assert property (dec_valid && $past(slot[MAJ_HI:MAJ_LO]) == MAJ_MM
		|-> dec_size == sasd_size_t'({$past(slot[SZ_HI_BIT]), $past(slot[SZ_LO_BIT])}))
		else $error("size code mismatch");
	AST_PERM8: assert property (dec_valid && dec_op == OP_HALF_PERM
		|-> dec_imm == $past(slot[P8_HI:P8_LO]) && dec_size == SZ_HALF)
		else $error("half permute selector wrong");
	AST_SHR5: assert property (dec_valid && dec_op == OP_SHR && dec_imm_sel == IMM_AMT5
		|-> dec_imm[4:0] == $past(slot[SHR5_HI:SHR5_LO]) && dec_size != SZ_FULL)
		else $error("fixed right shift count wrong");
	AST_HOLD: assert property (!take |=> $stable(dec_op) && !dec_valid && !dec_illegal)
		else $error("output changed without a slot");
	// The left count sits apart from the right count, so a swapped slice shows up here.
	AST_SHL5: assert property (dec_valid && dec_op == OP_SHL && dec_imm_sel == IMM_AMT5
		|-> dec_imm[4:0] == $past(slot[SHL5_HI:SHL5_LO]) && dec_size != SZ_FULL)
		else $error("fixed left shift count wrong");
	AST_PERM4: assert property (dec_valid && dec_op == OP_BYTE_PERM
		|-> dec_imm == {4'h0, $past(slot[P4_HI:P4_LO])} && dec_size == SZ_BYTE)
		else $error("byte permute pattern wrong");
	AST_ALU_FULL: assert property (take && slot[MAJ_HI:MAJ_LO] == MAJ_ALU
		&& slot[SZ_HI_BIT] && slot[SZ_LO_BIT] |=> dec_illegal)
		else $error("fourth size accepted for opcode 8");
	AST_AVG_SIZE: assert property (dec_valid && (dec_op == OP_AVG || dec_op == OP_AVG_DIFF)
		|-> dec_size == SZ_BYTE || dec_size == SZ_HALF)
		else $error("average decoded for word size");
	AST_MUL_SHR: assert property (dec_valid && dec_op == OP_MUL_SHR
		|-> dec_size == SZ_HALF && dec_imm == {6'h00, $past(slot[C2_HI:C2_LO])})
		else $error("multiply-shift count wrong");
endmodule

//--- sasd_issue_model.sv
// Issue pipeline model that presents instruction slots to the decoder.
`timescale 1ns/10ps
module sasd_issue_model (
	// Clock
	input  wire logic                        clock,
	// Slot towards the decoder
	output logic                             slot_valid,
	output logic [sasd_pkg::SLOT_W-1:0]      slot
);
	import sasd_pkg::*;
	initial begin
		slot_valid = 1'b0;
		slot       = '0;
	end
	// ==========================================================
	// Slot issue
	// Outside a valid cycle the bus carries the inverse of the last slot.
	// A decoder that captures without slot_valid then decodes garbage.
	task automatic send(input logic [SLOT_W-1:0] s, input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		slot_valid <= 1'b1;
		slot       <= s;
		@(posedge clock);
		slot_valid <= 1'b0;
		slot       <= ~s;
	endtask
endmodule

//--- testbench.sv
// Self-checking testbench for the SIMD decoder and its register slave.
`timescale 1ns/10ps
module testbench;
	import sasd_pkg::*;
	localparam logic [3:0] SKIP = 4'h8;
	logic                  clock;
	logic                  rstn;
	logic                  slot_valid;
	logic [SLOT_W-1:0]     slot;
	logic                  dec_valid;
	logic                  dec_illegal;
	sasd_op_t              dec_op;
	sasd_size_t            dec_size;
	logic [2:0]            dec_variant;
	sasd_imm_t             dec_imm_sel;
	logic [7:0]            dec_imm;
	logic [AW-1:0]         address;
	logic                  read;
	logic                  write;
	logic [31:0]           writedata;
	logic [3:0]            byteenable;
	logic [31:0]           readdata;
	logic                  waitrequest;
	logic [31:0]           rd;
	int                    miscompares;
	int                    tests_run;
	int                    n_leg;
	int                    n_ill;
	int                    cycles;
	// ==========================================================
	// Instances
	sasd_top i_dut (.clock(clock), .rstn(rstn), .slot_valid(slot_valid), .slot(slot),
		.dec_valid(dec_valid), .dec_illegal(dec_illegal), .dec_op(dec_op),
		.dec_size(dec_size), .dec_variant(dec_variant), .dec_imm_sel(dec_imm_sel),
		.dec_imm(dec_imm), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));
	sasd_issue_model i_issue (.clock(clock), .slot_valid(slot_valid), .slot(slot));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ==========================================================
	// Hang guard, well above the few hundred cycles the run needs.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [SLOT_W-1:0] m7(logic [1:0] sz, logic [1:0] a, logic [1:0] b,
		logic [1:0] c);
		return {MAJ_MM, sz[1], a, sz[0], 1'b0, c, b, 28'h0};
	endfunction
	function automatic logic [SLOT_W-1:0] m8(logic [1:0] sz, logic [3:0] x4, logic [1:0] b);
		return {MAJ_ALU, sz[1], 2'h1, sz[0], x4, b, 27'h0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic av(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clock);
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		write      <= wr;
		read       <= ~wr;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask
	// For legal decodes, size is expected from bits 36 and 33 of the slot itself.
	task automatic dec(input logic [SLOT_W-1:0] s, input sasd_op_t op, input logic [3:0] v);
		i_issue.send(s, 0);
		@(negedge clock);
		chk("valid", {31'h0, op != OP_NONE}, {31'h0, dec_valid});
		chk("illegal", {31'h0, op == OP_NONE}, {31'h0, dec_illegal});
		chk("op", op, dec_op);
		if (op == OP_NONE) begin
			n_ill++;
		end else begin
			n_leg++;
			chk("size", {30'h0, s[36], s[33]}, dec_size);
			if (!v[3]) begin
				chk("variant", v[2:0], dec_variant);
			end
		end
	endtask
	task automatic imm(input sasd_imm_t sel, input logic [7:0] val);
		chk("imm sel", sel, dec_imm_sel);
		chk("imm", val, dec_imm);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = 32'h0;
		byteenable = 4'hF;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		av(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
		chk("ctrl reset", 32'h1, rd);
		for (int b = 0; b < 4; b++) begin
			dec(m8(2'h0, 4'h0, b[1:0]), OP_ADD, b[3:0]);
			dec(m8(2'h1, 4'h1, b[1:0]), OP_SUB, b[3:0]);
		end
		dec(m8(2'h2, 4'h0, 2'h0), OP_ADD, 4'h0);
		dec(m8(2'h2, 4'h0, 2'h1), OP_NONE, SKIP);
		dec(m8(2'h2, 4'h1, 2'h3), OP_NONE, SKIP);
		dec(m8(2'h0, 4'h2, 2'h2), OP_AVG, 4'h0);
		dec(m8(2'h1, 4'h2, 2'h3), OP_AVG, V_RAZ);
		dec(m8(2'h0, 4'h2, 2'h0), OP_NONE, SKIP);
		dec(m8(2'h1, 4'h3, 2'h2), OP_AVG_DIFF, SKIP);
		dec(m8(2'h2, 4'h2, 2'h2), OP_NONE, SKIP);
		dec(m8(2'h2, 4'h3, 2'h2), OP_NONE, SKIP);
		for (int z = 0; z < 3; z++) begin
			for (int b = 0; b < 2; b++) begin
				dec(m8(z[1:0], 4'h9, b[1:0]), OP_CMP, b[3:0]);
			end
		end
		dec(m8(2'h0, 4'h9, 2'h2), OP_NONE, SKIP);
		dec(m8(2'h3, 4'h0, 2'h0), OP_NONE, SKIP);
		dec(m8(2'h0, 4'h0, 2'h0) ^ 41'h0C00000000, OP_NONE, SKIP);
		dec(m8(2'h1, 4'h4, 2'h2), OP_SHL_ADD, SKIP);
		imm(IMM_AMT2, 8'h02);
		dec(m8(2'h1, 4'h6, 2'h1), OP_SHR_ADD, SKIP);
		dec(m8(2'h0, 4'h4, 2'h1), OP_NONE, SKIP);
		dec(m7(2'h1, 2'h0, 2'h3, 2'h2), OP_MUL_SHR, V_SIGNED);
		imm(IMM_AMT2, 8'h02);
		dec(m7(2'h1, 2'h0, 2'h1, 2'h1), OP_MUL_SHR, V_UNSIGNED);
		dec(m7(2'h1, 2'h0, 2'h3, 2'h2) | 41'h100000000, OP_NONE, SKIP);
		for (int z = 0; z < 3; z += 2) begin
			dec(m7(z[1:0], 2'h2, 2'h0, 2'h2), OP_INTERLEAVE, V_RIGHT);
			dec(m7(z[1:0], 2'h2, 2'h2, 2'h2), OP_INTERLEAVE, V_LEFT);
			dec(m7(z[1:0], 2'h2, 2'h0, 2'h1), OP_WIDEN_IL, V_HIGH);
			dec(m7(z[1:0], 2'h2, 2'h2, 2'h1), OP_WIDEN_IL, V_LOW);
		end
		dec(m7(2'h0, 2'h2, 2'h1, 2'h0), OP_MIN, V_UNSIGNED);
		dec(m7(2'h0, 2'h2, 2'h1, 2'h1), OP_MAX, V_UNSIGNED);
		dec(m7(2'h0, 2'h2, 2'h3, 2'h2), OP_ABS_DIFF_SUM, SKIP);
		dec(m7(2'h1, 2'h2, 2'h0, 2'h0), OP_NARROW_SAT, V_UNSIGNED);
		dec(m7(2'h1, 2'h2, 2'h2, 2'h0), OP_NARROW_SAT, V_SIGNED);
		dec(m7(2'h1, 2'h2, 2'h3, 2'h0), OP_MIN, V_SIGNED);
		dec(m7(2'h1, 2'h2, 2'h3, 2'h1), OP_MAX, V_SIGNED);
		dec(m7(2'h1, 2'h2, 2'h1, 2'h3), OP_MUL_WIDEN, V_RIGHT);
		dec(m7(2'h1, 2'h2, 2'h3, 2'h3), OP_MUL_WIDEN, V_LEFT);
		dec(m7(2'h2, 2'h2, 2'h2, 2'h0), OP_NARROW_SAT, V_SIGNED);
		dec(m7(2'h2, 2'h2, 2'h0, 2'h0), OP_NONE, SKIP);
		dec(m7(2'h2, 2'h2, 2'h3, 2'h0), OP_NONE, SKIP);
		dec(m7(2'h0, 2'h3, 2'h2, 2'h2) | 41'hA00000, OP_BYTE_PERM, SKIP);
		imm(IMM_PERM4, 8'h0A);
		dec(m7(2'h1, 2'h3, 2'h2, 2'h2) | 41'hA500000, OP_HALF_PERM, SKIP);
		imm(IMM_PERM8, 8'hA5);
		for (int z = 1; z < 4; z++) begin
			dec(m7(z[1:0], 2'h0, 2'h2, 2'h0), OP_SHR, V_SIGNED);
			dec(m7(z[1:0], 2'h0, 2'h0, 2'h0), OP_SHR, V_UNSIGNED);
			dec(m7(z[1:0], 2'h0, 2'h0, 2'h1), OP_SHL, SKIP);
		end
		dec(m7(2'h1, 2'h1, 2'h3, 2'h0) | 41'h4C000, OP_SHR, V_SIGNED);
		imm(IMM_AMT5, 8'h13);
		dec(m7(2'h2, 2'h1, 2'h1, 2'h0), OP_SHR, V_UNSIGNED);
		dec(m7(2'h0, 2'h1, 2'h3, 2'h0), OP_NONE, SKIP);
		dec(m7(2'h2, 2'h3, 2'h1, 2'h1) | 41'h1B00000, OP_SHL, SKIP);
		imm(IMM_AMT5, 8'h1B);
		dec(m7(2'h3, 2'h3, 2'h1, 2'h1), OP_NONE, SKIP);
		dec(m7(2'h1, 2'h1, 2'h1, 2'h2), OP_NONE, SKIP);
		dec({4'h5, 37'h0}, OP_NONE, SKIP);
		// Register side: a write without byte lane 0 must leave decoding on.
		av(1'b1, REG_CTRL, 32'h0, 4'h0, rd);
		av(1'b1, 4'hC, 32'h0, 4'hF, rd);
		dec(m8(2'h0, 4'h0, 2'h0), OP_ADD, 4'h0);
		av(1'b0, 4'hC, 32'h0, 4'hF, rd);
		chk("unmapped", 32'h0, rd);
		av(1'b0, REG_DCNT, 32'h0, 4'hF, rd);
		chk("legal count", n_leg, rd);
		av(1'b0, REG_ICNT, 32'h0, 4'hF, rd);
		chk("illegal count", n_ill, rd);
		av(1'b1, REG_CTRL, 32'h0, 4'hF, rd);
		i_issue.send(m8(2'h0, 4'h0, 2'h0), 3);
		@(negedge clock);
		chk("off valid", 32'h0, {31'h0, dec_valid | dec_illegal});
		av(1'b1, REG_CTRL, 32'h3, 4'hF, rd);
		av(1'b0, REG_DCNT, 32'h0, 4'hF, rd);
		chk("cleared", 32'h0, rd);
		av(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
		chk("ctrl", 32'h1, rd);
		dec(m8(2'h1, 4'h1, 2'h0), OP_SUB, 4'h0);
		end_of_test();
	end
endmodule
